// ### src/tevq_pkg.sv
// Constants, register map and helper function of the touch event qualifier.
package tevq_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] TEVQ_OFS_TOUCH_IRQ_EN = 8'h27;
    localparam logic [7:0] TEVQ_OFS_GPIO_IRQ_EN  = 8'h28;
    localparam logic [7:0] TEVQ_OFS_SLEEP_SEL    = 8'h29;
    localparam logic [7:0] TEVQ_OFS_MULTI_CFG    = 8'h2A;
    localparam logic [7:0] TEVQ_OFS_LID_CFG      = 8'h2B;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] TEVQ_RST_TOUCH_IRQ_EN = 8'hFF;
    localparam logic [7:0] TEVQ_RST_GPIO_IRQ_EN  = 8'h00;
    localparam logic [7:0] TEVQ_RST_SLEEP_SEL    = 8'h00;
    localparam logic [7:0] TEVQ_RST_MULTI_CFG    = 8'h82;
    localparam logic [7:0] TEVQ_RST_LID_CFG      = 8'h00;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int TEVQ_BIT_GROUP_IRQ_EN   = 7;
    localparam int TEVQ_BIT_GROUP_SLEEP    = 7;
    localparam int TEVQ_BIT_BLOCK_EN       = 7;
    localparam int TEVQ_POS_BUTTON_THR     = 2;
    localparam int TEVQ_POS_GROUP_THR      = 0;
    localparam int TEVQ_BIT_LID_EN         = 7;
    localparam int TEVQ_BIT_PATTERN_SELECT = 1;
    localparam int TEVQ_BIT_LID_ALERT_EN   = 0;

    // Writable bits of the multi-touch and lid registers; the rest read as zero.
    localparam logic [7:0] TEVQ_MASK_MULTI_CFG = 8'h8F;
    localparam logic [7:0] TEVQ_MASK_LID_CFG   = 8'h83;

    // Number of buttons, grouped sensors and GPIO pins.
    localparam int TEVQ_NUM_BUTTONS = 7;
    localparam int TEVQ_NUM_GROUPED = 7;
    localparam int TEVQ_NUM_PINS    = 8;

    // Counts set bits of a sensor vector.
    function automatic logic [3:0] tevq_popcount(input logic [6:0] vec);
        logic [3:0] sum;
        sum = 4'h0;
        for (int i = 0; i < 7; i++)
        begin
            sum = sum + {3'h0, vec[i]};
        end
        return sum;
    endfunction

endpackage

// ### src/tevq_lid_if.sv
// Signals between the qualifier and its lid closure comparator.
`timescale 1ns/1ps
interface tevq_lid_if;
    logic [6:0] status1;
    logic [6:0] status2;
    logic [6:0] pattern1;
    logic [6:0] pattern2;
    logic       patternSelect;
    logic       hit;
    logic       patternsZero;

    modport owner
    (
        output status1, status2, pattern1, pattern2, patternSelect,
        input  hit, patternsZero
    );
    modport cmp
    (
        input  status1, status2, pattern1, pattern2, patternSelect,
        output hit, patternsZero
    );
endinterface

// ### src/tevq_lid_compare.sv
// Combinational lid closure pattern comparator.
`timescale 1ns/1ps
module tevq_lid_compare
    import tevq_pkg::*;
(
    tevq_lid_if.cmp lid
);

    // ------------------------------------------------------------------
    // Counts of set bits
    // ------------------------------------------------------------------
    wire  [3:0] statCnt1   = tevq_popcount(lid.status1);
    wire  [3:0] statCnt2   = tevq_popcount(lid.status2);
    wire  [3:0] patCnt1    = tevq_popcount(lid.pattern1);
    wire  [3:0] patCnt2    = tevq_popcount(lid.pattern2);
    wire  [4:0] statTotal  = {1'b0, statCnt1} + {1'b0, statCnt2};
    wire  [4:0] patTotal   = {1'b0, patCnt1} + {1'b0, patCnt2};

    // ------------------------------------------------------------------
    // Match decisions
    // ------------------------------------------------------------------
    wire        countHit   = (statCnt1 >= patCnt1) || (statCnt2 >= patCnt2)
                          || (statTotal >= patTotal);
    wire        exactHit   = ((lid.pattern1 & ~lid.status1) == 7'h00)
                          && ((lid.pattern2 & ~lid.status2) == 7'h00);

    assign lid.patternsZero = (lid.pattern1 == 7'h00) && (lid.pattern2 == 7'h00);
    assign lid.hit = !lid.patternsZero && (lid.patternSelect ? exactHit : countHit);

endmodule

// ### src/tevq_qualifier.sv
// Touch and GPIO event qualifier with sleep channel, multi-touch and lid closure control.
`timescale 1ns/1ps
// Functional notes
// - Group enable bit 7 (reset 1) lets up/down/tap/hold gestures raise the interrupt.
// - Seven button enables gate each button touch onto the interrupt; all seven reset set.
// - Eight GPIO enables, reset clear, gate GPIO status bits onto the interrupt.
// - Sleep channel select at 29h, reset 00h, picks sensors sampled in Sleep.
// - Group sleep bit samples grouped sensors in Sleep, their gestures still interrupt.
// - Per-button sleep bits sample that button in Sleep; unselected buttons stay silent.
// - Newly added sleep sensors may get one longer conversion, then normal cycles.
// - Blocking enabled (reset) accepts touches up to threshold until accepted ones release.
// - Button threshold 00..11 means 1..4 touches; exceeding it flags multi-touch.
// - Group threshold 00..11 means 2,3,4,1 touches; exceeding it flags multi-touch.
// - Lid enable (reset 0) combines lid status with patterns to flag lid events.
// - Pattern select clear compares counts of set bits, not bit positions.
// - Pattern select set flags when every pattern bit is also set in status.
// - Lid alert enable raises the alert pin on a lid closure event.
// - Enable registers 27h (FFh) and 28h (00h) decide which touch and GPIO events interrupt.
// - Count mode flags on button count, group count or total count reaching pattern.
// - Both patterns zero disable lid detection and clear the lid status bit.
module tevq_qualifier
    import tevq_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    // Register port from the serial interface engine
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrEn,
    input  wire logic       regRdEn,
    output logic      [7:0] regRdData,
    output logic            regHit,
    // Sensing results
    input  wire logic       sleepState,
    input  wire logic       conversionDone,
    input  wire logic [6:0] buttonTouch,
    input  wire logic [6:0] groupTouch,
    input  wire logic [3:0] groupGesture,
    input  wire logic [7:0] pinStatus,
    input  wire logic [6:0] lidStatus1,
    input  wire logic [6:0] lidStatus2,
    input  wire logic [6:0] lidPattern1,
    input  wire logic [6:0] lidPattern2,
    // Qualified results
    output logic      [6:0] buttonSample,
    output logic            groupedSample,
    output logic      [6:0] extendConversion,
    output logic      [6:0] buttonAccepted,
    output logic            buttonMultiTouch,
    output logic            groupMultiTouch,
    output logic            noiseIsLid,
    output logic            lidEvent,
    output logic            lidStatusClear,
    output logic            alertOut,
    output logic            irqOut
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    // The port widths are fixed, so the package counts must agree with them.
    if (TEVQ_NUM_BUTTONS != 7 || TEVQ_NUM_GROUPED != 7 || TEVQ_NUM_PINS != 8)
    begin : g_count_check
        $error("tevq_qualifier serves seven buttons, seven grouped sensors and eight pins only");
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    logic [7:0] touchIrqEn_q;
    logic [7:0] pinIrqEn_q;
    logic [7:0] sleepSel_q;
    logic [7:0] multiCfg_q;
    logic [7:0] lidCfg_q;

    wire        hitTouch  = regAddr == TEVQ_OFS_TOUCH_IRQ_EN;
    wire        hitPin    = regAddr == TEVQ_OFS_GPIO_IRQ_EN;
    wire        hitSleep  = regAddr == TEVQ_OFS_SLEEP_SEL;
    wire        hitMulti  = regAddr == TEVQ_OFS_MULTI_CFG;
    wire        hitLid    = regAddr == TEVQ_OFS_LID_CFG;
    wire        hitAny    = hitTouch | hitPin | hitSleep | hitMulti | hitLid;

    wire  [7:0] rdMux     = hitTouch ? touchIrqEn_q
                          : hitPin   ? pinIrqEn_q
                          : hitSleep ? sleepSel_q
                          : hitMulti ? multiCfg_q
                          : hitLid   ? lidCfg_q
                          : 8'h00;

    // Each register has its own write strobe so that its update block stays small.
    wire        wrTouch   = regWrEn && hitTouch;
    wire        wrPin     = regWrEn && hitPin;
    wire        wrSleep   = regWrEn && hitSleep;
    wire        wrMulti   = regWrEn && hitMulti;
    wire        wrLid     = regWrEn && hitLid;

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            touchIrqEn_q <= TEVQ_RST_TOUCH_IRQ_EN;
        end
        else if (wrTouch)
        begin
            touchIrqEn_q <= regWrData;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            pinIrqEn_q <= TEVQ_RST_GPIO_IRQ_EN;
        end
        else if (wrPin)
        begin
            pinIrqEn_q <= regWrData;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            sleepSel_q <= TEVQ_RST_SLEEP_SEL;
        end
        else if (wrSleep)
        begin
            sleepSel_q <= regWrData;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            multiCfg_q <= TEVQ_RST_MULTI_CFG;
        end
        else if (wrMulti)
        begin
            multiCfg_q <= regWrData & TEVQ_MASK_MULTI_CFG;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            lidCfg_q <= TEVQ_RST_LID_CFG;
        end
        else if (wrLid)
        begin
            lidCfg_q <= regWrData & TEVQ_MASK_LID_CFG;
        end
    end

    // Read data and hit flag are registered one cycle after the read strobe.
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            regRdData <= 8'h00;
            regHit    <= 1'b0;
        end
        else if (regRdEn)
        begin
            regRdData <= rdMux;
            regHit    <= hitAny;
        end
    end

    // ------------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------------
    wire        groupIrqEn   = touchIrqEn_q[TEVQ_BIT_GROUP_IRQ_EN];
    wire  [6:0] buttonIrqEn  = touchIrqEn_q[6:0];
    wire        groupSleep   = sleepSel_q[TEVQ_BIT_GROUP_SLEEP];
    wire  [6:0] buttonSleep  = sleepSel_q[6:0];
    wire        blockEn      = multiCfg_q[TEVQ_BIT_BLOCK_EN];
    wire  [1:0] buttonThrFld = multiCfg_q[TEVQ_POS_BUTTON_THR +: 2];
    wire  [1:0] groupThrFld  = multiCfg_q[TEVQ_POS_GROUP_THR +: 2];
    wire        lidEn        = lidCfg_q[TEVQ_BIT_LID_EN];
    wire        patternSel   = lidCfg_q[TEVQ_BIT_PATTERN_SELECT];
    wire        lidAlertEn   = lidCfg_q[TEVQ_BIT_LID_ALERT_EN];

    wire  [3:0] buttonThr    = {2'b00, buttonThrFld} + 4'h1;
    wire  [3:0] groupThr     = (groupThrFld == 2'b11) ? 4'h1
                             : {2'b00, groupThrFld} + 4'h2;

    // ------------------------------------------------------------------
    // Sleep channel selection
    // ------------------------------------------------------------------
    wire  [6:0] buttonLive   = sleepState ? buttonSleep : 7'h7F;
    wire        groupLive    = sleepState ? groupSleep : 1'b1;
    wire  [6:0] buttonSeen   = buttonTouch & buttonLive;
    wire  [6:0] groupSeen    = groupTouch & {7{groupLive}};
    wire  [3:0] gestureSeen  = groupGesture & {4{groupLive}};
    wire  [6:0] newlyAdded   = regWrData[6:0] & ~buttonSleep;
    wire        groupAdded   = regWrData[TEVQ_BIT_GROUP_SLEEP] & ~groupSleep;
    wire        sleepRewrite = regWrEn && hitSleep && sleepState;

    logic [6:0] extend_q;
    logic [6:0] extend_d;

    // A sensor added during Sleep keeps its longer first conversion until a conversion ends in a cycle with no Sleep write to 29h.
    assign extend_d = sleepRewrite ? (extend_q | newlyAdded | {7{groupAdded}})
                    : conversionDone ? 7'h00
                    : extend_q;

    // ------------------------------------------------------------------
    // Multiple touch blocking
    // ------------------------------------------------------------------
    logic [3:0] prefixCnt [0:7];
    logic [6:0] firstTouches;

    assign prefixCnt[0] = 4'h0;

    genvar gi;
    generate
        for (gi = 0; gi < TEVQ_NUM_BUTTONS; gi++)
        begin : g_pick
            assign prefixCnt[gi + 1] = prefixCnt[gi] + {3'h0, buttonSeen[gi]};
            assign firstTouches[gi]  = buttonSeen[gi] && (prefixCnt[gi] < buttonThr);
        end
    endgenerate

    logic [6:0] accepted_q;
    logic [6:0] accepted_d;
    wire  [6:0] stillHeld   = accepted_q & buttonSeen;

    // While blocking, each accepted button drops out on its release; no new ones are taken until all are released.
    assign accepted_d = !blockEn            ? buttonSeen
                      : (stillHeld != 7'h00) ? stillHeld
                      : firstTouches;

    wire  [3:0] buttonCnt   = tevq_popcount(buttonSeen);
    wire  [3:0] groupCnt    = tevq_popcount(groupSeen);
    wire        buttonMulti = buttonCnt > buttonThr;
    wire        groupMulti  = groupCnt > groupThr;

    // ------------------------------------------------------------------
    // Lid closure comparison
    // ------------------------------------------------------------------
    tevq_lid_if lidBus ();

    assign lidBus.status1       = lidStatus1;
    assign lidBus.status2       = lidStatus2;
    assign lidBus.pattern1      = lidPattern1;
    assign lidBus.pattern2      = lidPattern2;
    assign lidBus.patternSelect = patternSel;

    tevq_lid_compare u_lid_compare
    (
        .lid (lidBus.cmp)
    );

    wire        lidFlag     = lidEn && lidBus.hit;
    wire        lidClear    = lidEn && lidBus.patternsZero;

    // ------------------------------------------------------------------
    // Interrupt qualification
    // ------------------------------------------------------------------
    wire        groupIrq    = groupIrqEn && (gestureSeen != 4'h0);
    wire        buttonIrq   = (accepted_d & buttonIrqEn) != 7'h00;
    wire        pinIrq      = (pinStatus & pinIrqEn_q) != 8'h00;
    wire        multiIrq    = blockEn && (buttonMulti || groupMulti);
    wire        lidIrq      = lidFlag && lidAlertEn;
    wire        irqAny      = groupIrq | buttonIrq | pinIrq | multiIrq | lidIrq;

    // ------------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            extend_q      <= 7'h00;
            buttonSample  <= 7'h7F;
            groupedSample <= 1'b1;
        end
        else
        begin
            extend_q      <= extend_d;
            buttonSample  <= buttonLive;
            groupedSample <= groupLive;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            accepted_q <= 7'h00;
        end
        else
        begin
            accepted_q <= accepted_d;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            buttonMultiTouch <= 1'b0;
            groupMultiTouch  <= 1'b0;
        end
        else
        begin
            buttonMultiTouch <= buttonMulti;
            groupMultiTouch  <= groupMulti;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            noiseIsLid     <= 1'b0;
            lidEvent       <= 1'b0;
            lidStatusClear <= 1'b0;
            alertOut       <= 1'b0;
        end
        else
        begin
            noiseIsLid     <= lidEn;
            lidEvent       <= lidFlag;
            lidStatusClear <= lidClear;
            alertOut       <= lidIrq;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            irqOut <= 1'b0;
        end
        else
        begin
            irqOut <= irqAny;
        end
    end

    assign extendConversion = extend_q;
    assign buttonAccepted   = accepted_q;

endmodule

// ### bench/tevq_qualifier_chk.sv
// Concurrent checks bound to the ports of the touch event qualifier.
`timescale 1ns/1ps
module tevq_qualifier_chk
(
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       nrst,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrEn,
    input wire logic       regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic       regHit,
    // Sensing and qualified results
    input wire logic       conversionDone,
    input wire logic [6:0] buttonTouch,
    input wire logic [6:0] lidPattern1,
    input wire logic [6:0] lidPattern2,
    input wire logic [6:0] extendConversion,
    input wire logic [6:0] buttonAccepted,
    input wire logic       buttonMultiTouch,
    input wire logic       lidEvent,
    input wire logic       alertOut
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    sequence s_wr_sel;
        regWrEn && regAddr == 8'h29 && !regRdEn;
    endsequence
    sequence s_rd_sel;
        regRdEn && regAddr == 8'h29 && !regWrEn;
    endsequence
    chk_sel_readback: assert property (s_wr_sel ##1 !regWrEn ##1 s_rd_sel |=> regRdData == $past(regWrData, 3))
        else $error("sleep select read back differs from written byte");
    chk_unmapped_read: assert property (regRdEn && (regAddr < 8'h27 || regAddr > 8'h2B) |=> regRdData == 8'h00 && !regHit)
        else $error("unmapped read not answered with zero and no hit");
    chk_reserved_zero: assert property (regRdEn && regAddr == 8'h2A |=> regRdData[6:4] == 3'h0)
        else $error("reserved multi touch bits read nonzero");
    chk_lid_disabled: assert property (lidPattern1 == 7'h00 && lidPattern2 == 7'h00 |=> !lidEvent)
        else $error("lid event with both patterns zero");
    chk_alert_cause: assert property (alertOut |-> lidEvent)
        else $error("alert without lid event");
    chk_extend_clear: assert property (conversionDone && !regWrEn |=> extendConversion == 7'h00)
        else $error("extended conversion not cleared after conversion");
    chk_accept_subset: assert property (buttonAccepted != 7'h00 |-> (buttonAccepted & ~$past(buttonTouch)) == 7'h00)
        else $error("accepted button that was not touched");
    chk_multi_count: assert property (buttonMultiTouch |-> $countones($past(buttonTouch)) > 1)
        else $error("multi touch flagged with fewer than two touches");
endmodule

bind tevq_qualifier tevq_qualifier_chk u_chk (.*);

// ### bench/tevq_host_model.sv
// Host side model that issues single byte register writes and reads.
`timescale 1ns/1ps
module tevq_host_model
(
    // Clock
    input  wire logic       clk_sys,
    // Read answer
    input  wire logic [7:0] regRdData,
    input  wire logic       regHit,
    // Request
    output logic      [7:0] regAddr   = 8'h00,
    output logic      [7:0] regWrData = 8'h00,
    output logic            regWrEn   = 1'b0,
    output logic            regRdEn   = 1'b0
);
    // A quiet cycle follows each strobe so it never toggles twice in one time step.
    task automatic access(input logic wr, input logic [7:0] adr, input logic [7:0] dat,
                          output logic [7:0] q, output logic h);
        regAddr = adr;
        regWrData = dat;
        regWrEn = wr;
        regRdEn = ~wr;
        @(posedge clk_sys);
        #1;
        q = regRdData;
        h = regHit;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = ~adr;
        regWrData = ~dat;
        @(posedge clk_sys);
        #1;
    endtask
endmodule

// ### bench/testbench.sv
// Self-checking testbench of the touch event qualifier.
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module testbench;
    logic       clk_sys = 1'b0, nrst = 1'b0, regWrEn, regRdEn, regHit, hit;
    logic       sleepState = 1'b0, conversionDone = 1'b0, groupedSample, buttonMultiTouch, groupMultiTouch;
    logic       noiseIsLid, lidEvent, lidStatusClear, alertOut, irqOut;
    logic [7:0] regAddr, regWrData, regRdData, rdv, pinStatus = 8'h00;
    logic [6:0] buttonTouch = 7'h00, groupTouch = 7'h00, lidStatus1 = 7'h00, lidStatus2 = 7'h00;
    logic [6:0] lidPattern1 = 7'h00, lidPattern2 = 7'h00, buttonSample, extendConversion, buttonAccepted;
    logic [3:0] groupGesture = 4'h0;
    int         miscompares = 0, total_checks = 0, cycles = 0;
    tevq_qualifier u_dut (.*);
    tevq_host_model u_host (.*);
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            results();
        end
    end
    task automatic results();
        if (miscompares == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic step();
        @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_host.access(1'b1, a, d, rdv, hit);
    endtask
    task automatic rd(input logic [7:0] a);
        u_host.access(1'b0, a, 8'h00, rdv, hit);
    endtask
    task automatic t_regs();
        logic [7:0] adr [5] = '{8'h27, 8'h28, 8'h29, 8'h2A, 8'h2B};
        logic [7:0] dflt [5] = '{8'hFF, 8'h00, 8'h00, 8'h82, 8'h00};
        for (int i = 0; i < 5; i++)
        begin
            rd(adr[i]);
            `CHK({rdv, hit}, {dflt[i], 1'b1})
        end
        rd(8'h2C);
        `CHK({rdv, hit}, 9'h000)
        wr(8'h2A, 8'hFF);
        rd(8'h2A);
        `CHK(rdv, 8'h8F)
        wr(8'h2A, 8'h82);
    endtask
    task automatic t_irq();
        buttonTouch = 7'h40;
        step();
        `CHK({irqOut, buttonAccepted}, 8'hC0)
        wr(8'h27, 8'hBF);
        `CHK(irqOut, 1'b0)
        buttonTouch = 7'h00;
        groupGesture = 4'h8;
        step();
        `CHK(irqOut, 1'b1)
        wr(8'h27, 8'h7F);
        `CHK(irqOut, 1'b0)
        groupGesture = 4'h0;
        pinStatus = 8'h80;
        step();
        `CHK(irqOut, 1'b0)
        wr(8'h28, 8'h80);
        `CHK(irqOut, 1'b1)
        wr(8'h28, 8'h7F);
        `CHK(irqOut, 1'b0)
        pinStatus = 8'h00;
        wr(8'h27, 8'hFF);
    endtask
    task automatic t_multi();
        int g;
        for (int c = 0; c < 4; c++)
        begin
            g = (c == 3) ? 1 : c + 2;
            wr(8'h2A, 8'(8'h80 | (c << 2) | c));
            buttonTouch = 7'((2 << (c + 1)) - 1);
            groupTouch = 7'((2 << g) - 1);
            step();
            `CHK({buttonMultiTouch, groupMultiTouch}, 2'b11)
            `CHK(buttonAccepted, 7'((1 << (c + 1)) - 1))
            buttonTouch = 7'((1 << (c + 1)) - 1);
            groupTouch = 7'((1 << g) - 1);
            step();
            `CHK({buttonMultiTouch, groupMultiTouch}, 2'b00)
            buttonTouch = 7'h00;
            groupTouch = 7'h00;
        end
        wr(8'h2A, 8'h82);
        buttonTouch = 7'h08;
        step();
        buttonTouch = 7'h09;
        step();
        `CHK(buttonAccepted, 7'h08)
        wr(8'h2A, 8'h02);
        buttonTouch = 7'h07;
        step();
        `CHK(buttonAccepted, 7'h07)
        buttonTouch = 7'h00;
        wr(8'h2A, 8'h82);
    endtask
    task automatic t_sleep();
        sleepState = 1'b1;
        buttonTouch = 7'h02;
        step();
        `CHK({buttonSample, groupedSample, irqOut}, 9'h000)
        wr(8'h29, 8'h02);
        `CHK({extendConversion, buttonSample, irqOut}, 15'h0205)
        wr(8'h29, 8'h82); // A real host would now force recalibration of the added channels.
        `CHK({extendConversion, groupedSample}, 8'hFF)
        rd(8'h29);
        `CHK(rdv, 8'h82)
        conversionDone = 1'b1;
        step();
        conversionDone = 1'b0;
        `CHK(extendConversion, 7'h00)
        sleepState = 1'b0;
        buttonTouch = 7'h00;
        step();
        `CHK(buttonSample, 7'h7F)
        wr(8'h29, 8'h00);
    endtask
    task automatic t_lid();
        lidPattern1 = 7'h03;
        lidPattern2 = 7'h01;
        lidStatus1 = 7'h01;
        wr(8'h2B, 8'h81);
        `CHK({lidEvent, noiseIsLid}, 2'b01)
        lidStatus1 = 7'h03;
        step();
        `CHK({lidEvent, alertOut, irqOut}, 3'b111)
        lidStatus1 = 7'h00;
        lidStatus2 = 7'h40;
        step();
        `CHK(lidEvent, 1'b1)
        lidStatus2 = 7'h00;
        lidPattern1 = 7'h05;
        lidPattern2 = 7'h00;
        lidStatus1 = 7'h06;
        wr(8'h2B, 8'h83);
        `CHK(lidEvent, 1'b0)
        lidStatus1 = 7'h07;
        wr(8'h2B, 8'h82);
        `CHK({lidEvent, alertOut}, 2'b10)
        lidPattern1 = 7'h00;
        step();
        `CHK({lidEvent, lidStatusClear}, 2'b01)
        lidPattern1 = 7'h05;
        wr(8'h2B, 8'h00);
        `CHK({lidEvent, noiseIsLid}, 2'b00)
    endtask
    initial
    begin
        repeat (3) @(posedge clk_sys);
        #1;
        nrst = 1'b1;
        t_regs();
        t_irq();
        t_multi();
        t_sleep();
        t_lid();
        results();
    end
endmodule
